// ---- verilog/rmvl_regs.svh ----
// register map and constants for the reset mode vector loader
// assumes a 32-bit AXI4-Lite register bus and a 32-bit boot memory read port
`ifndef RMVL_REGS_SVH
`define RMVL_REGS_SVH

`define RMVL_MODE_ADDR 32'h000FFFF8
`define RMVL_VEC_ADDR 32'h000FFFFC
`define RMVL_MODE_MSB 31
`define RMVL_MODE_LSB 24
`define RMVL_MODE_GOOD 8'h07
`define RMVL_SEL_INTERNAL 3'h0
`define RMVL_SEL_EXTERNAL 3'h1

`define RMVL_OFF_MODE 4'h0
`define RMVL_OFF_STATUS 4'h4
`define RMVL_OFF_VECTOR 4'h8
`define RMVL_ST_DONE 0
`define RMVL_ST_EXT 1
`define RMVL_ST_BADSEL 2
`define RMVL_ST_BADMODE 3
`define RMVL_ST_SEL_LSB 4
`define RMVL_ST_SEL_MSB 6
`define RMVL_RESP_OKAY 2'h0
`define RMVL_RESP_SLVERR 2'h2

`endif

// ---- verilog/rmvl_pkg.sv ----
// types shared by the reset mode vector loader
// assumes rmvl_regs.svh is included by design files for the constants
package rmvl_pkg;
  typedef enum logic [2:0] {
    RMVL_LATCH,
    RMVL_MODE_REQ,
    RMVL_MODE_WAIT,
    RMVL_VEC_REQ,
    RMVL_VEC_WAIT,
    RMVL_DONE
  } rmvl_state_e;
endpackage

// ---- verilog/rmvl_axil_slave.sv ----
// axi4-lite read/write slave exposing the loader's read-only registers
// assumes one clock, synchronous active-high reset; all writes are refused
`timescale 1ns/1ps
`default_nettype none
`include "rmvl_regs.svh"

module rmvl_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] regMode,
  input wire logic [31:0] regStatus,
  input wire logic [31:0] regVector
);
  logic haveAw;
  logic haveW;
  wire takeAw = awvalid && awready;
  wire takeW = wvalid && wready;
  wire isMode = araddr == `RMVL_OFF_MODE;
  wire isStatus = araddr == `RMVL_OFF_STATUS;
  wire isVector = araddr == `RMVL_OFF_VECTOR;
  wire mapped = isMode || isStatus || isVector;
  wire [31:0] readMux = isMode ? regMode : isStatus ? regStatus : isVector ? regVector : 32'h0;

  // ---------------------------------------------------------------
  // write channel: every write is answered but nothing is stored
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b0;
      wready <= 1'b0;
      haveAw <= 1'b0;
      haveW <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RMVL_RESP_OKAY;
    end else begin
      awready <= !haveAw && !takeAw && !bvalid;
      wready <= !haveW && !takeW && !bvalid;
      if (takeAw) haveAw <= 1'b1;
      if (takeW) haveW <= 1'b1;
      if ((haveAw || takeAw) && (haveW || takeW) && !bvalid) begin
        // program writes never reach the mode byte
        bvalid <= 1'b1;
        bresp <= `RMVL_RESP_SLVERR;
        haveAw <= 1'b0;
        haveW <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RMVL_RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= readMux;
        rresp <= mapped ? `RMVL_RESP_OKAY : `RMVL_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/rmvl_loader.sv ----
// reset-time mode byte and reset vector loader with register view
// assumes boot memory answers a read request with memRdValid some cycles later
// and that mode pins are static board straps synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "rmvl_regs.svh"

// How it works
// - pins all low select the internal area for both the mode fetch and the vector fetch.
// - the three select pins decide how both reset fetches are performed.
// - fetched byte goes into the mode register, which drives the mode output.
// - mode register reloads on every reset; software writes are refused.
// - mode byte is bits 31..24 at FFFF8; vector is the word at FFFFC.
module rmvl_loader (
  input wire logic clk,
  input wire logic rst,
  input wire logic bootSelPin2,
  input wire logic bootSelPin1,
  input wire logic bootSelPin0,
  output logic memRdReq,
  output logic [31:0] memRdAddr,
  output logic memRdExternal,
  input wire logic memRdValid,
  input wire logic [31:0] memRdData,
  output logic [7:0] bootModeByte,
  output logic [31:0] resetVector,
  output logic pcLoad,
  output logic loadDone,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  rmvl_pkg::rmvl_state_e state;
  logic [2:0] bootSel;
  logic useExternal;
  logic badSel;
  logic badMode;
  rmvl_pkg::rmvl_state_e next_state;

  wire [2:0] pinSel = {bootSelPin2, bootSelPin1, bootSelPin0};
  wire selInternal = pinSel == `RMVL_SEL_INTERNAL;
  wire selExternal = pinSel == `RMVL_SEL_EXTERNAL;
  // every setting but all low, the external one included, is recorded for software to
  wire selBad = !selInternal;
  wire [7:0] fetchedMode = memRdData[`RMVL_MODE_MSB:`RMVL_MODE_LSB];

  // ---------------------------------------------------------------
  // status word seen by software
  // ---------------------------------------------------------------
  // bit 2 is set for every strap setting other than all low, the external one included
  wire [31:0] statusWord = {25'h0, bootSel, badMode, badSel, useExternal, loadDone};

  // ---------------------------------------------------------------
  // state decode
  // ---------------------------------------------------------------
  wire inLatch = state == rmvl_pkg::RMVL_LATCH;
  wire inModeReq = state == rmvl_pkg::RMVL_MODE_REQ;
  wire inModeWait = state == rmvl_pkg::RMVL_MODE_WAIT;
  wire inVecReq = state == rmvl_pkg::RMVL_VEC_REQ;
  wire inVecWait = state == rmvl_pkg::RMVL_VEC_WAIT;
  // a valid outside the two wait states is ignored, so a stray answer cannot load
  wire modeArrived = inModeWait && memRdValid;
  wire vecArrived = inVecWait && memRdValid;
  wire issueReq = inModeReq || inVecReq;
  // mode word always goes out first, the vector word second
  wire [31:0] next_memRdAddr = inModeReq ? `RMVL_MODE_ADDR : inVecReq ? `RMVL_VEC_ADDR : memRdAddr;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      rmvl_pkg::RMVL_LATCH: begin
        next_state = rmvl_pkg::RMVL_MODE_REQ;
      end
      rmvl_pkg::RMVL_MODE_REQ: begin
        next_state = rmvl_pkg::RMVL_MODE_WAIT;
      end
      rmvl_pkg::RMVL_MODE_WAIT: begin
        if (memRdValid) begin
          next_state = rmvl_pkg::RMVL_VEC_REQ;
        end
      end
      rmvl_pkg::RMVL_VEC_REQ: begin
        next_state = rmvl_pkg::RMVL_VEC_WAIT;
      end
      rmvl_pkg::RMVL_VEC_WAIT: begin
        if (memRdValid) begin
          next_state = rmvl_pkg::RMVL_DONE;
        end
      end
      rmvl_pkg::RMVL_DONE: begin
        next_state = rmvl_pkg::RMVL_DONE;
      end
      default: begin
        next_state = rmvl_pkg::RMVL_LATCH;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= rmvl_pkg::RMVL_LATCH;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // strap capture
  // ---------------------------------------------------------------
  // straps caught after release, never inside the reset branch
  always_ff @(posedge clk) begin
    if (rst) begin
      bootSel <= 3'h0;
      useExternal <= 1'h0;
      memRdExternal <= 1'h0;
      badSel <= 1'h0;
    end else if (inLatch) begin
      bootSel <= pinSel;
      useExternal <= selExternal;
      memRdExternal <= selExternal;
      badSel <= selBad;
    end
  end

  // ---------------------------------------------------------------
  // fetch requests
  // ---------------------------------------------------------------
  // one request pulse per fetch, address held until the next one
  always_ff @(posedge clk) begin
    if (rst) begin
      memRdReq <= 1'h0;
      memRdAddr <= 32'h0;
    end else begin
      memRdReq <= issueReq;
      memRdAddr <= next_memRdAddr;
    end
  end

  // ---------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------
  // rst is the merged reset of every source, so the byte reloads each time
  always_ff @(posedge clk) begin
    if (rst) begin
      bootModeByte <= 8'h0;
      badMode <= 1'h0;
    end else if (modeArrived) begin
      bootModeByte <= fetchedMode;
      badMode <= fetchedMode != `RMVL_MODE_GOOD;
    end
  end

  // ---------------------------------------------------------------
  // reset vector and pc load
  // ---------------------------------------------------------------
  // no retry: a vector fetch that never answers leaves the pc load parked
  always_ff @(posedge clk) begin
    if (rst) begin
      resetVector <= 32'h0;
      pcLoad <= 1'h0;
      loadDone <= 1'h0;
    end else begin
      pcLoad <= vecArrived;
      if (vecArrived) begin
        resetVector <= memRdData;
        loadDone <= 1'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register view
  // ---------------------------------------------------------------
  rmvl_axil_slave u_bus (
    .clk(clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regMode({24'h0, bootModeByte}),
    .regStatus(statusWord),
    .regVector(resetVector)
  );
endmodule
`default_nettype wire

// ---- verification/rmvl_monitor.sv ----
// port checker for the loader
// assumes sync active-high rst, bound into rmvl_loader
`timescale 1ns/1ps
`default_nettype none
`include "rmvl_regs.svh"
module rmvl_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic bootSelPin2,
  input wire logic bootSelPin1,
  input wire logic bootSelPin0,
  input wire logic memRdReq,
  input wire logic [31:0] memRdAddr,
  input wire logic memRdExternal,
  input wire logic memRdValid,
  input wire logic [31:0] memRdData,
  input wire logic [7:0] bootModeByte,
  input wire logic [31:0] resetVector,
  input wire logic pcLoad,
  input wire logic loadDone,
  input wire logic [1:0] bresp,
  input wire logic bvalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_mode_first: assert property ($fell(rst) |-> ##[1:3] memRdReq && memRdAddr == `RMVL_MODE_ADDR)
    else $error("first fetch is not the mode word");
  chk_area_sel: assert property (memRdReq |=> memRdExternal == ({bootSelPin2, bootSelPin1, bootSelPin0} == `RMVL_SEL_EXTERNAL))
    else $error("fetch area does not follow straps");
  chk_mode_load: assert property (memRdValid && !memRdReq && !loadDone && memRdAddr == `RMVL_MODE_ADDR
    |=> {bootModeByte, 24'h0} == ($past(memRdData) & 32'hFF000000) ##[1:2] memRdReq && memRdAddr == `RMVL_VEC_ADDR)
    else $error("mode byte not taken from top byte");
  chk_vec_load: assert property (memRdValid && !memRdReq && !loadDone && memRdAddr == `RMVL_VEC_ADDR
    |=> pcLoad && resetVector == $past(memRdData))
    else $error("vector not loaded with pc load");
  chk_pc_pulse: assert property (pcLoad |-> loadDone ##1 !pcLoad)
    else $error("pc load not a single pulse");
  chk_no_refetch: assert property (loadDone |-> !memRdReq)
    else $error("fetch after load done");
  chk_mode_held: assert property (loadDone |=> $stable(bootModeByte) && $stable(resetVector))
    else $error("mode register changed after load");
  chk_write_refused: assert property (bvalid |-> bresp == `RMVL_RESP_SLVERR)
    else $error("write to mode register accepted");
  chk_reset_clear: assert property (disable iff (1'b0) rst |=> !loadDone && !pcLoad && !memRdReq)
    else $error("outputs not cleared by reset");
  cover property (pcLoad);
  cover property (bvalid);
  cover property (memRdReq && memRdExternal);
endmodule
bind rmvl_loader rmvl_monitor mon_u (.clk, .rst, .bootSelPin2, .bootSelPin1, .bootSelPin0, .memRdReq, .memRdAddr,
  .memRdExternal, .memRdValid, .memRdData, .bootModeByte, .resetVector, .pcLoad, .loadDone, .bresp, .bvalid);
`default_nettype wire

// ---- verification/rmvl_boot_mem.sv ----
// boot memory model answering one read lat+1 cycles after it samples the request
// assumes one request outstanding at a time
`timescale 1ns/1ps
`default_nettype none
`include "rmvl_regs.svh"
module rmvl_boot_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic memRdReq,
  input wire logic [31:0] memRdAddr,
  input wire logic [31:0] modeWord,
  input wire logic [31:0] vecWord,
  input wire logic [3:0] lat,
  output logic memRdValid,
  output logic [31:0] memRdData
);
  logic [3:0] cnt;
  logic busy;
  always_ff @(posedge clk) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData; // data bus not held outside the answer
    if (rst) begin
      busy <= 1'b0;
      memRdData <= 32'h0;
    end else if (memRdReq) begin
      busy <= 1'b1;
      cnt <= lat;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      memRdValid <= 1'b1;
      memRdData <= (memRdAddr == `RMVL_MODE_ADDR) ? modeWord : vecWord;
    end
  end
endmodule
`default_nettype wire

// ---- verification/rmvl_loader_test.sv ----
// self-checking bench for rmvl_loader
// assumes rmvl_boot_mem partner and the bound monitor
`timescale 1ns/1ps
`default_nettype none
`include "rmvl_regs.svh"
module rmvl_loader_test;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, memRdReq, memRdExternal, memRdValid, pcLoad, loadDone;
  logic awready, wready, bvalid, arready, rvalid;
  logic [2:0] sel;
  logic [3:0] awaddr, araddr, wstrb, lat;
  logic [31:0] wdata, rdata, memRdAddr, memRdData, resetVector, modeWord, vecWord, rd;
  logic [1:0] bresp, rresp, rr;
  logic [7:0] bootModeByte;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  logic [2:0] selTab [3] = '{3'h0, 3'h1, 3'h7};
  logic [31:0] modeTab [3] = '{32'h07A5C3E1, 32'h06000000, 32'h07FFFFFF};
  logic [31:0] vecTab [3] = '{32'h00012340, 32'h8000BEEF, 32'h0000F00C};
  rmvl_loader dut_u (.clk, .rst, .bootSelPin2(sel[2]), .bootSelPin1(sel[1]), .bootSelPin0(sel[0]), .memRdReq,
    .memRdAddr, .memRdExternal, .memRdValid, .memRdData, .bootModeByte, .resetVector, .pcLoad, .loadDone, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  rmvl_boot_mem mem_u (.clk, .rst, .memRdReq, .memRdAddr, .modeWord, .vecWord, .lat, .memRdValid, .memRdData);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      finish_test();
    end
  end
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    aw = 1'b0;
    w = 1'b0;
    do begin
      @(posedge clk);
      aw = aw | awready;
      w = w | wready;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge clk); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    {sel, lat} = 7'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 12'h00F;
    {wdata, modeWord, vecWord} = 96'h0;
    for (int i = 0; i < 3; i++) begin
      sel <= selTab[i];
      lat <= 4'(i * 4);
      modeWord <= modeTab[i];
      vecWord <= vecTab[i];
      do_reset();
      repeat (3) @(posedge clk);
      do_reset(); // second reset lands while a fetch is pending
      while (loadDone !== 1'b1) @(posedge clk);
      check("mode", {24'h0, bootModeByte}, {24'h0, modeTab[i][31:24]});
      check("vector", resetVector, vecTab[i]);
      check("external", {31'h0, memRdExternal}, {31'h0, selTab[i] == `RMVL_SEL_EXTERNAL});
      rd_reg(`RMVL_OFF_STATUS);
      check("status", rd, {25'h0, selTab[i], modeTab[i][31:24] != `RMVL_MODE_GOOD,
        selTab[i] != `RMVL_SEL_INTERNAL, selTab[i] == `RMVL_SEL_EXTERNAL, 1'b1});
      wr_reg(`RMVL_OFF_MODE, 32'h000000FF);
      check("wresp", {30'h0, rr}, {30'h0, `RMVL_RESP_SLVERR});
      rd_reg(`RMVL_OFF_MODE);
      check("modereg", rd, {24'h0, modeTab[i][31:24]});
      rd_reg(`RMVL_OFF_VECTOR);
      check("vecreg", rd, vecTab[i]);
      rd_reg(4'hC);
      check("unmapped", rd, 32'h0);
      check("unmapresp", {30'h0, rr}, {30'h0, `RMVL_RESP_SLVERR});
      @(posedge clk);
    end
    finish_test();
  end
endmodule
`default_nettype wire
